// [logic/leb_regs.svh]
// Operation
// - Set bits ORs immediate, flags, one cycle
// - Clear bits ANDs with FFh minus immediate
// - Increment/decrement by one, carry untouched
// - Test sets flags, register keeps value
// - Clear XORs self; set loads ones, no flags
// - Relative jump 2, call 3 cycles
// - Compare-skip-equal skips 1 or 2 words
// - Compares subtract, flags only, one cycle
// - Skip on working register bit state
// - Skip on I/O register bit state
// - Flag branches, one or two cycles
// - Equal/not-equal branch on zero flag
// - Carry branches, lower and same-or-higher
// - Minus/plus branch on negative flag
// - Signed branches on negative XOR overflow
// - Half-carry branches, no flag change
// - T flag branches, same target
// - Overflow branches on overflow flag
// - Interrupt enable branches on I flag
//
// Constants of the execution block: map, fields, reset values, cycle counts.
// Assumes inclusion by the design files of this block only.
`ifndef LEB_REGS_SVH
`define LEB_REGS_SVH

// ****************
// APB map
// ****************
`define LEB_ADDR_INSTR  12'h000
`define LEB_ADDR_STATUS 12'h004
`define LEB_ADDR_PC     12'h008
`define LEB_ADDR_FLAGS  12'h00C
`define LEB_RF_PAGE     5'h02
`define LEB_IO_PAGE     5'h04

// ****************
// Instruction word fields
// ****************
`define LEB_F_OP_HI 31
`define LEB_F_OP_LO 26
`define LEB_F_RD_HI 25
`define LEB_F_RD_LO 21
`define LEB_F_RR_HI 20
`define LEB_F_RR_LO 16
`define LEB_F_TWO   12
`define LEB_F_K_HI  11

// ****************
// Status flag positions
// ****************
`define LEB_SF_C 0
`define LEB_SF_Z 1
`define LEB_SF_N 2
`define LEB_SF_V 3
`define LEB_SF_S 4
`define LEB_SF_H 5
`define LEB_SF_T 6
`define LEB_SF_I 7

// ****************
// Reset values and cycle counts
// ****************
`define LEB_RST_PC    12'h000
`define LEB_RST_FLAGS 8'h00
`define LEB_RST_BYTE  8'h00
`define LEB_CYC_ONE   3'h1
`define LEB_CYC_TWO   3'h2
`define LEB_CYC_CALL  3'h3
`define LEB_CYC_RET   3'h4

`endif

// [logic/leb_pkg.sv]
// Types shared by the execution block files.
// Opcode numbering follows declaration order, starting at zero.
package leb_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_SET_BITS_IMM, OP_CLEAR_BITS_IMM, OP_INCREMENT, OP_DECREMENT,
    OP_TEST_ZERO_MINUS, OP_CLEAR_REGISTER, OP_SET_REGISTER, OP_RELATIVE_JUMP,
    OP_RELATIVE_CALL, OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN,
    OP_COMPARE_SKIP_EQUAL, OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY,
    OP_COMPARE_IMMEDIATE, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_MINUS, OP_BRANCH_PLUS,
    OP_BRANCH_GE_SIGNED, OP_BRANCH_LT_SIGNED, OP_BRANCH_HALFCARRY_SET,
    OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TFLAG_SET, OP_BRANCH_TFLAG_CLEAR,
    OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_INT_ENABLED,
    OP_BRANCH_INT_DISABLED
  } leb_op_t;

  typedef enum logic {ST_IDLE, ST_EXEC} leb_state_t;

endpackage

// [logic/leb_alu.sv]
// Data path of the logic, increment and compare operations.
// Purely combinational; the caller commits result and flags.
`timescale 1ns/1ps
`include "leb_regs.svh"

module leb_alu (
  input  wire leb_pkg::leb_op_t op,
  input  wire logic [7:0]       a,
  input  wire logic [7:0]       b,
  input  wire logic [7:0]       status_flags_reg_in,
  output logic      [7:0]       res,
  output logic                  wr_en,
  output logic      [7:0]       status_flags_reg_out
);

  logic [7:0] r;
  logic       cin;
  logic       v;
  logic       c;
  logic       h;
  logic       z;
  logic       upd;
  logic       upd_ch;

  always_comb
  begin
    cin    = (op == leb_pkg::OP_COMPARE_WITH_CARRY) ? status_flags_reg_in[`LEB_SF_C] : 1'b0;
    r      = a;
    v      = 1'b0;
    upd    = 1'b0;
    upd_ch = 1'b0;
    wr_en  = 1'b0;
    case (op)
      leb_pkg::OP_SET_BITS_IMM:
      begin
        r     = a | b;
        upd   = 1'b1;
        wr_en = 1'b1;
      end
      leb_pkg::OP_CLEAR_BITS_IMM:
      begin
        r     = a & (8'hFF - b);
        upd   = 1'b1;
        wr_en = 1'b1;
      end
      leb_pkg::OP_INCREMENT:
      begin
        r     = a + 8'h01;
        v     = (a == 8'h7F);
        upd   = 1'b1;
        wr_en = 1'b1;
      end
      leb_pkg::OP_DECREMENT:
      begin
        r     = a - 8'h01;
        v     = (a == 8'h80);
        upd   = 1'b1;
        wr_en = 1'b1;
      end
      leb_pkg::OP_TEST_ZERO_MINUS:
      begin
        r   = a & a;
        upd = 1'b1;
      end
      leb_pkg::OP_CLEAR_REGISTER:
      begin
        r     = a ^ a;
        upd   = 1'b1;
        wr_en = 1'b1;
      end
      leb_pkg::OP_SET_REGISTER:
      begin
        r     = 8'hFF;
        wr_en = 1'b1;
      end
      leb_pkg::OP_COMPARE_REGS, leb_pkg::OP_COMPARE_WITH_CARRY, leb_pkg::OP_COMPARE_IMMEDIATE:
      begin
        r      = a - b - {7'h00, cin};
        v      = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        upd    = 1'b1;
        upd_ch = 1'b1;
      end
      default:
      begin
        r = a;
      end
    endcase
    c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    // Chained compare keeps zero only if the lower byte was zero too
    z = (r == 8'h00) & ((op != leb_pkg::OP_COMPARE_WITH_CARRY) | status_flags_reg_in[`LEB_SF_Z]);
    status_flags_reg_out = status_flags_reg_in;
    if (upd)
    begin
      status_flags_reg_out[`LEB_SF_Z] = z;
      status_flags_reg_out[`LEB_SF_N] = r[7];
      status_flags_reg_out[`LEB_SF_V] = v;
      status_flags_reg_out[`LEB_SF_S] = r[7] ^ v;
    end
    if (upd_ch)
    begin
      status_flags_reg_out[`LEB_SF_C] = c;
      status_flags_reg_out[`LEB_SF_H] = h;
    end
    res = r;
  end

endmodule

// [logic/leb_exec.sv]
// Execution block: register file, program counter, flags, return stack,
// one instruction word executed per APB write, with documented cycle counts.
// Assumes a single APB master on pclk; the register files are loaded over APB.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "leb_regs.svh"

module leb_exec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ****************
  // State
  // ****************
  logic [7:0]          rf [32];
  logic [7:0]          io [32];
  logic [11:0]         stack [16];
  logic [3:0]          sp;
  logic [11:0]         pc;
  logic [7:0]          status_flags_reg;
  logic [31:0]         ir;
  logic [2:0]          cnt;
  logic [2:0]          last_cycles;
  leb_pkg::leb_state_t state;

  leb_pkg::leb_op_t op;
  logic [4:0]       rd_idx;
  logic [4:0]       rr_idx;
  logic [2:0]       bsel;
  logic [7:0]       imm;
  logic [7:0]       a;
  logic [7:0]       b;
  logic             taken;
  logic [2:0]       need;
  logic             last;
  logic [11:0]      next_pc;
  logic [11:0]      br_pc;
  logic [11:0]      skip_pc;
  logic [7:0]       alu_res;
  logic             alu_wr;
  logic [7:0]       alu_status_flags_reg;
  logic             wr_ok;
  logic             idle_wr;
  logic [31:0]      rd_mux;

  // ****************
  // Helpers
  // ****************
  function automatic logic is_imm(leb_pkg::leb_op_t o);
    return o == leb_pkg::OP_SET_BITS_IMM || o == leb_pkg::OP_CLEAR_BITS_IMM ||
           o == leb_pkg::OP_COMPARE_IMMEDIATE;
  endfunction

  function automatic logic is_skip(leb_pkg::leb_op_t o);
    return o == leb_pkg::OP_COMPARE_SKIP_EQUAL || (o >= leb_pkg::OP_SKIP_REG_BIT_CLEAR &&
           o <= leb_pkg::OP_SKIP_IO_BIT_SET);
  endfunction

  function automatic logic is_branch(leb_pkg::leb_op_t o);
    return o >= leb_pkg::OP_BRANCH_FLAG_SET;
  endfunction

  function automatic logic mapped(logic [11:0] ad);
    return ad == `LEB_ADDR_INSTR || ad == `LEB_ADDR_STATUS || ad == `LEB_ADDR_PC ||
           ad == `LEB_ADDR_FLAGS ||
           (ad[1:0] == 2'b00 && (ad[11:7] == `LEB_RF_PAGE || ad[11:7] == `LEB_IO_PAGE));
  endfunction

  // Opcodes past the last defined one run as a one-cycle no-op
  assign op      = (ir[`LEB_F_OP_HI:`LEB_F_OP_LO] > 6'(leb_pkg::OP_BRANCH_INT_DISABLED)) ?
                   leb_pkg::OP_NOP : leb_pkg::leb_op_t'(ir[`LEB_F_OP_HI:`LEB_F_OP_LO]);
  assign rd_idx  = ir[`LEB_F_RD_HI:`LEB_F_RD_LO];
  assign rr_idx  = ir[`LEB_F_RR_HI:`LEB_F_RR_LO];
  assign bsel    = rr_idx[2:0];
  assign imm     = ir[7:0];
  assign a       = rf[rd_idx];
  assign b       = is_imm(op) ? imm : rf[rr_idx];

  // ****************
  // Condition and timing
  // ****************
  always_comb
  begin
    case (op)
      leb_pkg::OP_COMPARE_SKIP_EQUAL:     taken = (a == b);
      leb_pkg::OP_SKIP_REG_BIT_CLEAR:     taken = ~a[bsel];
      leb_pkg::OP_SKIP_REG_BIT_SET:       taken = a[bsel];
      leb_pkg::OP_SKIP_IO_BIT_CLEAR:      taken = ~io[rd_idx][bsel];
      leb_pkg::OP_SKIP_IO_BIT_SET:        taken = io[rd_idx][bsel];
      leb_pkg::OP_BRANCH_FLAG_SET:        taken = status_flags_reg[bsel];
      leb_pkg::OP_BRANCH_FLAG_CLEAR:      taken = ~status_flags_reg[bsel];
      leb_pkg::OP_BRANCH_EQUAL:           taken = status_flags_reg[`LEB_SF_Z];
      leb_pkg::OP_BRANCH_NOT_EQUAL:       taken = ~status_flags_reg[`LEB_SF_Z];
      leb_pkg::OP_BRANCH_CARRY_SET:       taken = status_flags_reg[`LEB_SF_C];
      leb_pkg::OP_BRANCH_CARRY_CLEAR:     taken = ~status_flags_reg[`LEB_SF_C];
      leb_pkg::OP_BRANCH_MINUS:           taken = status_flags_reg[`LEB_SF_N];
      leb_pkg::OP_BRANCH_PLUS:            taken = ~status_flags_reg[`LEB_SF_N];
      leb_pkg::OP_BRANCH_GE_SIGNED:
        taken = ~(status_flags_reg[`LEB_SF_N] ^ status_flags_reg[`LEB_SF_V]);
      leb_pkg::OP_BRANCH_LT_SIGNED:
        taken = status_flags_reg[`LEB_SF_N] ^ status_flags_reg[`LEB_SF_V];
      leb_pkg::OP_BRANCH_HALFCARRY_SET:   taken = status_flags_reg[`LEB_SF_H];
      leb_pkg::OP_BRANCH_HALFCARRY_CLEAR: taken = ~status_flags_reg[`LEB_SF_H];
      leb_pkg::OP_BRANCH_TFLAG_SET:       taken = status_flags_reg[`LEB_SF_T];
      leb_pkg::OP_BRANCH_TFLAG_CLEAR:     taken = ~status_flags_reg[`LEB_SF_T];
      leb_pkg::OP_BRANCH_OVERFLOW_SET:    taken = status_flags_reg[`LEB_SF_V];
      leb_pkg::OP_BRANCH_OVERFLOW_CLEAR:  taken = ~status_flags_reg[`LEB_SF_V];
      leb_pkg::OP_BRANCH_INT_ENABLED:     taken = status_flags_reg[`LEB_SF_I];
      leb_pkg::OP_BRANCH_INT_DISABLED:    taken = ~status_flags_reg[`LEB_SF_I];
      default:                            taken = 1'b0;
    endcase
  end

  always_comb
  begin
    case (op)
      leb_pkg::OP_RELATIVE_JUMP:     need = `LEB_CYC_TWO;
      leb_pkg::OP_RELATIVE_CALL:     need = `LEB_CYC_CALL;
      leb_pkg::OP_SUBROUTINE_RETURN,
      leb_pkg::OP_INTERRUPT_RETURN:  need = `LEB_CYC_RET;
      default:                       need = (taken && (is_skip(op) || is_branch(op))) ? `LEB_CYC_TWO : `LEB_CYC_ONE;
    endcase
  end

  assign last    = (state == leb_pkg::ST_EXEC) && (cnt == need - 3'h1);
  // Branch offsets are 7 bits, jump offsets fill the counter width
  assign br_pc   = pc + {{5{ir[6]}}, ir[6:0]} + 12'h001;
  assign skip_pc = pc + (ir[`LEB_F_TWO] ? 12'h003 : 12'h002);

  always_comb
  begin
    case (op)
      leb_pkg::OP_RELATIVE_JUMP,
      leb_pkg::OP_RELATIVE_CALL:     next_pc = pc + ir[`LEB_F_K_HI:0] + 12'h001;
      leb_pkg::OP_SUBROUTINE_RETURN,
      leb_pkg::OP_INTERRUPT_RETURN:  next_pc = stack[sp - 4'h1];
      default:
        if (taken && is_branch(op))
          next_pc = br_pc;
        else if (taken && is_skip(op))
          next_pc = skip_pc;
        else
          next_pc = pc + 12'h001;
    endcase
  end

  leb_alu u_alu (
    .op       (op),
    .a        (a),
    .b        (b),
    .status_flags_reg_in  (status_flags_reg),
    .res      (alu_res),
    .wr_en    (alu_wr),
    .status_flags_reg_out (alu_status_flags_reg)
  );

  // ****************
  // APB slave, zero wait states
  // ****************
  assign wr_ok   = psel & penable & pready & pwrite;
  // Register writes, launches included, are dropped mid-instruction
  assign idle_wr = wr_ok & (state == leb_pkg::ST_IDLE);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (paddr == `LEB_ADDR_INSTR)
      rd_mux = ir;
    else if (paddr == `LEB_ADDR_STATUS)
      rd_mux = {13'h0000, last_cycles, 4'h0, sp, 7'h00, state == leb_pkg::ST_EXEC};
    else if (paddr == `LEB_ADDR_PC)
      rd_mux = {20'h00000, pc};
    else if (paddr == `LEB_ADDR_FLAGS)
      rd_mux = {24'h000000, status_flags_reg};
    else if (paddr[1:0] == 2'b00 && paddr[11:7] == `LEB_RF_PAGE)
      rd_mux = {24'h000000, rf[paddr[6:2]]};
    else if (paddr[1:0] == 2'b00 && paddr[11:7] == `LEB_IO_PAGE)
      rd_mux = {24'h000000, io[paddr[6:2]]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable & ~pready;
      prdata  <= rd_mux;
      pslverr <= psel & ~penable & ~pready & ~mapped(paddr);
    end
  end

  // ****************
  // Sequencer
  // ****************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= leb_pkg::ST_IDLE;
      cnt         <= 3'h0;
      ir          <= 32'h0000_0000;
      last_cycles <= 3'h0;
    end
    else
    begin
      case (state)
        leb_pkg::ST_IDLE:
          if (idle_wr && paddr == `LEB_ADDR_INSTR)
          begin
            ir    <= pwdata;
            cnt   <= 3'h0;
            state <= leb_pkg::ST_EXEC;
          end
        leb_pkg::ST_EXEC:
          if (last)
          begin
            last_cycles <= need;
            state       <= leb_pkg::ST_IDLE;
          end
          else
            cnt <= cnt + 3'h1;
        default:
          state <= leb_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc <= `LEB_RST_PC;
    else if (last)
      pc <= next_pc;
    else if (idle_wr && paddr == `LEB_ADDR_PC)
      pc <= pwdata[11:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_flags_reg <= `LEB_RST_FLAGS;
    else if (last && op == leb_pkg::OP_INTERRUPT_RETURN)
      status_flags_reg[`LEB_SF_I] <= 1'b1;
    else if (last)
      status_flags_reg <= alu_status_flags_reg;
    else if (idle_wr && paddr == `LEB_ADDR_FLAGS)
      status_flags_reg <= pwdata[7:0];
  end

  // Stack wraps silently; software owns depth
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp <= 4'h0;
      for (int i = 0; i < 16; i++)
        stack[i] <= `LEB_RST_PC;
    end
    else if (last && op == leb_pkg::OP_RELATIVE_CALL)
    begin
      stack[sp] <= pc + 12'h001;
      sp        <= sp + 4'h1;
    end
    else if (last && (op == leb_pkg::OP_SUBROUTINE_RETURN || op == leb_pkg::OP_INTERRUPT_RETURN))
      sp <= sp - 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < 32; i++)
        rf[i] <= `LEB_RST_BYTE;
    else if (last && alu_wr)
      rf[rd_idx] <= alu_res;
    else if (idle_wr && paddr[1:0] == 2'b00 && paddr[11:7] == `LEB_RF_PAGE)
      rf[paddr[6:2]] <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < 32; i++)
        io[i] <= `LEB_RST_BYTE;
    else if (idle_wr && paddr[1:0] == 2'b00 && paddr[11:7] == `LEB_IO_PAGE)
      io[paddr[6:2]] <= pwdata[7:0];
  end

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SET_BITS_OR: assert property (last && op == leb_pkg::OP_SET_BITS_IMM |=>
    rf[$past(rd_idx)] == ($past(a) | $past(imm))) else $error("set bits result wrong");
  AST_CLEAR_BITS_AND: assert property (last && op == leb_pkg::OP_CLEAR_BITS_IMM |=>
    rf[$past(rd_idx)] == ($past(a) & ~$past(imm))) else $error("clear bits result wrong");
  AST_INCDEC_CARRY: assert property (last && (op == leb_pkg::OP_INCREMENT || op == leb_pkg::OP_DECREMENT)
    |=> $stable(status_flags_reg[`LEB_SF_C])) else $error("carry changed");
  AST_TEST_KEEPS: assert property (last && op == leb_pkg::OP_TEST_ZERO_MINUS |=>
    rf[$past(rd_idx)] == $past(a) && status_flags_reg[`LEB_SF_Z] == ($past(a) == 8'h00))
    else $error("test altered register");
  AST_SET_REG_FLAGS: assert property (last && op == leb_pkg::OP_SET_REGISTER |=>
    $stable(status_flags_reg) && rf[$past(rd_idx)] == 8'hFF) else $error("set register wrong");
  AST_JUMP_LEN: assert property (state == leb_pkg::ST_EXEC && cnt == 3'h0 &&
    op == leb_pkg::OP_RELATIVE_JUMP |-> !last ##1 last) else $error("jump length wrong");
  AST_CALL_LEN: assert property (state == leb_pkg::ST_EXEC && cnt == 3'h0 &&
    op == leb_pkg::OP_RELATIVE_CALL |-> !last [*2] ##1 last) else $error("call length wrong");
  AST_RET_LEN: assert property (state == leb_pkg::ST_EXEC && cnt == 3'h0 &&
    op == leb_pkg::OP_INTERRUPT_RETURN |-> ##3 last ##1 status_flags_reg[`LEB_SF_I])
    else $error("return timing or I flag wrong");
  AST_SKIP_PC: assert property (last && is_skip(op) && taken |=> pc == $past(skip_pc))
    else $error("skip target wrong");
  AST_COMPARE_NOSTORE: assert property (last && op == leb_pkg::OP_COMPARE_REGS |=>
    rf[$past(rd_idx)] == $past(a)) else $error("compare stored result");
  AST_BRANCH_PC: assert property (last && is_branch(op) |=>
    pc == ($past(taken) ? $past(br_pc) : $past(pc) + 12'h001)) else $error("branch target wrong");

  COV_JUMP: cover property (last && op == leb_pkg::OP_RELATIVE_JUMP);
  COV_BRANCH_TAKEN: cover property (last && is_branch(op) && taken);
  COV_SKIP_TAKEN: cover property (last && is_skip(op) && taken);
  COV_INTERRUPT_RETURN: cover property (last && op == leb_pkg::OP_INTERRUPT_RETURN);

endmodule

// [bench/logic_and_branch_exec_test.sv]
// Self-checking bench for the execution block, driven over APB.
// Assumes leb_pkg is compiled first; registers are reached at the block's map.
`timescale 1ns/1ps
module logic_and_branch_exec_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdat;
  logic        rerr;
  int          failures;
  int          checked;

  leb_exec leb_exec_i (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // ****************
  // Bus and compare tasks
  // ****************
  task chk(string s, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // Ends one cycle after release, so psel is never assigned twice in a step
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      failures++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Loads operands, flags and pc, runs one word, then checks cycles, register, flags and pc
  task run(logic [5:0] o, logic [4:0] d, logic [4:0] r, logic t, logic [11:0] k, logic [7:0] a,
           logic [7:0] b, logic [7:0] f, logic [7:0] ea, logic [7:0] ef, logic [11:0] epc, logic [2:0] ec);
    int n;
    n = 0;
    apb(1'b1, {4'h1, 1'b0, d, 2'h0}, {24'h0, a});
    apb(1'b1, {4'h1, 1'b0, r, 2'h0}, {24'h0, b});
    apb(1'b1, {4'h2, 1'b0, d, 2'h0}, {24'h0, a});
    apb(1'b1, 12'h00C, {24'h0, f});
    apb(1'b1, 12'h008, 32'h100);
    apb(1'b1, 12'h000, {o, d, r, 3'h0, t, k});
    do
    begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end
    while (rdat[0] !== 1'b0 && n < 20);
    chk("cycles", {29'h0, ec}, {29'h0, rdat[18:16]});
    apb(1'b0, {4'h1, 1'b0, d, 2'h0}, 32'h0);
    chk("reg", {24'h0, ea}, rdat);
    apb(1'b0, 12'h00C, 32'h0);
    chk("flags", {24'h0, ef}, rdat);
    apb(1'b0, 12'h008, 32'h0);
    chk("pc", {20'h0, epc}, rdat);
  endtask

  // ****************
  // Scenarios
  // ****************
  task branches();
    int         bs [8];
    logic [7:0] fv [4];
    logic [7:0] m;
    logic       c;
    bs = '{1, 0, 2, 2, 5, 6, 3, 7};
    for (int j = 0; j < 16; j++)
    begin
      m = 8'h01 << bs[j/2];
      fv = '{8'h00, 8'hFF, m, ~m};
      for (int i = 0; i < 4; i++)
      begin
        c = (j/2 == 3) ? ~(fv[i][2] ^ fv[i][3]) : fv[i][bs[j/2]];
        c = c ^ j[0];
        run(6'(int'(leb_pkg::OP_BRANCH_EQUAL) + j), 5'h02, 5'h03, 1'b0, 12'h07E, 8'h00, 8'h00, fv[i], 8'h00,
            fv[i], c ? 12'h0FF : 12'h101, c ? 3'h2 : 3'h1);
      end
    end
  endtask

  task flag_branches();
    logic [7:0] f;
    logic       c;
    for (int s = 0; s < 8; s++)
      for (int p = 0; p < 4; p++)
      begin
        f = p[1] ? ~(8'h01 << s) : (8'h01 << s);
        c = f[s] ^ p[0];
        run(6'(int'(leb_pkg::OP_BRANCH_FLAG_SET) + p % 2), 5'h02, 5'(s), 1'b0, 12'h005, 8'h00, 8'h00, f, 8'h00, f,
            c ? 12'h106 : 12'h101, c ? 3'h2 : 3'h1);
      end
  endtask

  task final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial
  begin
    #2000000;
    failures++;
    final_report();
  end

  initial
  begin
    failures = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk("pc reset", 32'h0, rdat);
    apb(1'b0, 12'h00C, 32'h0);
    chk("flags reset", 32'h0, rdat);
    apb(1'b0, 12'h300, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    run(leb_pkg::OP_SET_BITS_IMM, 5'h01, 5'h01, 1'b0, 12'h0F0, 8'h0F, 8'h0F, 8'h49, 8'hFF, 8'h55, 12'h101, 3'h1);
    run(leb_pkg::OP_CLEAR_BITS_IMM, 5'h01, 5'h01, 1'b0, 12'h05A, 8'h5A, 8'h5A, 8'h0D, 8'h00, 8'h03, 12'h101, 3'h1);
    run(leb_pkg::OP_CLEAR_BITS_IMM, 5'h01, 5'h01, 1'b0, 12'h00F, 8'hFF, 8'hFF, 8'h00, 8'hF0, 8'h14, 12'h101, 3'h1);
    run(leb_pkg::OP_INCREMENT, 5'h01, 5'h01, 1'b0, 12'h000, 8'h7F, 8'h7F, 8'h01, 8'h80, 8'h0D, 12'h101, 3'h1);
    run(leb_pkg::OP_INCREMENT, 5'h01, 5'h01, 1'b0, 12'h000, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h02, 12'h101, 3'h1);
    run(leb_pkg::OP_DECREMENT, 5'h01, 5'h01, 1'b0, 12'h000, 8'h80, 8'h80, 8'h01, 8'h7F, 8'h19, 12'h101, 3'h1);
    run(leb_pkg::OP_DECREMENT, 5'h01, 5'h01, 1'b0, 12'h000, 8'h01, 8'h01, 8'h00, 8'h00, 8'h02, 12'h101, 3'h1);
    run(leb_pkg::OP_TEST_ZERO_MINUS, 5'h01, 5'h01, 1'b0, 12'h000, 8'h80, 8'h80, 8'h08, 8'h80, 8'h14, 12'h101, 3'h1);
    run(leb_pkg::OP_TEST_ZERO_MINUS, 5'h01, 5'h01, 1'b0, 12'h000, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 12'h101, 3'h1);
    run(leb_pkg::OP_CLEAR_REGISTER, 5'h01, 5'h01, 1'b0, 12'h000, 8'h3C, 8'h3C, 8'h0C, 8'h00, 8'h02, 12'h101, 3'h1);
    run(leb_pkg::OP_SET_REGISTER, 5'h01, 5'h01, 1'b0, 12'h000, 8'h12, 8'h12, 8'h2B, 8'hFF, 8'h2B, 12'h101, 3'h1);
    run(leb_pkg::OP_COMPARE_REGS, 5'h02, 5'h03, 1'b0, 12'h000, 8'h10, 8'h20, 8'h00, 8'h10, 8'h15, 12'h101, 3'h1);
    run(leb_pkg::OP_COMPARE_WITH_CARRY, 5'h02, 5'h03, 1'b0, 12'h000, 8'h20, 8'h1F, 8'h03, 8'h20, 8'h22, 12'h101, 3'h1);
    run(leb_pkg::OP_COMPARE_IMMEDIATE, 5'h02, 5'h03, 1'b0, 12'h001, 8'h80, 8'h55, 8'h00, 8'h80, 8'h38, 12'h101, 3'h1);
    run(leb_pkg::OP_COMPARE_SKIP_EQUAL, 5'h02, 5'h03, 1'b1, 12'h000, 8'h44, 8'h44, 8'hA5, 8'h44, 8'hA5, 12'h103, 3'h2);
    run(leb_pkg::OP_COMPARE_SKIP_EQUAL, 5'h02, 5'h03, 1'b1, 12'h000, 8'h44, 8'h45, 8'hA5, 8'h44, 8'hA5, 12'h101, 3'h1);
    run(leb_pkg::OP_SKIP_REG_BIT_CLEAR, 5'h02, 5'h03, 1'b0, 12'h000, 8'hF7, 8'hF7, 8'h00, 8'hF7, 8'h00, 12'h102, 3'h2);
    run(leb_pkg::OP_SKIP_REG_BIT_SET, 5'h02, 5'h03, 1'b0, 12'h000, 8'hF7, 8'hF7, 8'h00, 8'hF7, 8'h00, 12'h101, 3'h1);
    run(leb_pkg::OP_SKIP_IO_BIT_SET, 5'h02, 5'h03, 1'b1, 12'h000, 8'h08, 8'h08, 8'h00, 8'h08, 8'h00, 12'h103, 3'h2);
    run(leb_pkg::OP_SKIP_IO_BIT_CLEAR, 5'h02, 5'h03, 1'b1, 12'h000, 8'h08, 8'h08, 8'h00, 8'h08, 8'h00, 12'h101, 3'h1);
    run(leb_pkg::OP_RELATIVE_JUMP, 5'h00, 5'h00, 1'b0, 12'h800, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 12'h901, 3'h2);
    run(leb_pkg::OP_RELATIVE_CALL, 5'h00, 5'h00, 1'b0, 12'h005, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 12'h106, 3'h3);
    run(leb_pkg::OP_SUBROUTINE_RETURN, 5'h00, 5'h00, 1'b0, 12'h000, 8'h00, 8'h00, 8'h5A, 8'h00, 8'h5A, 12'h101, 3'h4);
    run(leb_pkg::OP_RELATIVE_CALL, 5'h00, 5'h00, 1'b0, 12'h7FF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 12'h900, 3'h3);
    run(leb_pkg::OP_INTERRUPT_RETURN, 5'h00, 5'h00, 1'b0, 12'h000, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 12'h101, 3'h4);
    branches();
    flag_branches();
    final_report();
  end
endmodule
